// File: rtl/sdc_map.svh
`ifndef SDC_MAP_SVH
`define SDC_MAP_SVH
// Geometry
`define SDC_BANKS          4
`define SDC_ROW_W          13
`define SDC_ROWS           8192
// Command encodings {ras_n,cas_n,we_n}
`define SDC_CMD_NOP        3'b111
`define SDC_CMD_ACT        3'b011
`define SDC_CMD_RD         3'b101
`define SDC_CMD_WR         3'b100
`define SDC_CMD_BST        3'b110
`define SDC_CMD_PRE        3'b010
`define SDC_CMD_REF        3'b001
`define SDC_CMD_LMR        3'b000
// Address fields
`define SDC_AP_BIT         10
`define SDC_COL_X4_HI      11
`define SDC_MODE_W         12
// Latencies in clocks
`define SDC_DQM_RD_LAT     2
// Timing in ns, counts in 5 ns cycles (least times round up)
`define SDC_CLK_NS         5
`define SDC_PRE_WAIT_NS    18
`define SDC_REF_WAIT_NS    66
`define SDC_ACT_WAIT_NS    18
`define SDC_CYC(ns)        (((ns) + `SDC_CLK_NS - 1) / `SDC_CLK_NS)
// Self refresh internal refresh period, in mclk cycles
`define SDC_SELF_TICK_DIV  1562
// Reset values
`define SDC_MODE_RST       12'h000
`endif

// File: rtl/sdc_pkg.sv
package sdc_pkg;
   // Per-bank state
   typedef enum logic [2:0] {
      BK_IDLE, BK_ACTIVATING, BK_ROW_OPEN, BK_READING, BK_WRITING, BK_PRECHARGING
   } sdc_bank_state_type;
   // Command pins sampled on one edge
   typedef struct packed {
      logic        cs_n;
      logic        ras_n;
      logic        cas_n;
      logic        we_n;
      logic        cke;
      logic [1:0]  ba;
      logic [12:0] addr;
   } sdc_cmd_type;
   // Decoded command
   typedef enum logic [3:0] {
      DC_INHIBIT, DC_NOP, DC_ACT, DC_RD, DC_WR, DC_BST, DC_PRE, DC_AREF, DC_SREF, DC_LMR
   } sdc_dec_type;
endpackage

// File: rtl/sdc_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdc_map.svh"
// One bank's state machine and open-row holder
module sdc_bank #(
   parameter int PRE_CYC = 4,
   parameter int ACT_CYC = 4
) (
   input  wire logic                       mclk,
   input  wire logic                       reset,
   input  wire logic                       do_act,
   input  wire logic                       do_pre,
   input  wire logic                       do_rd,
   input  wire logic                       do_wr,
   input  wire logic                       burst_end,
   input  wire logic                       ap,
   input  wire logic [12:0]                row_in,
   output sdc_pkg::sdc_bank_state_type     state,
   output logic [12:0]                     open_row
);
   logic [3:0] wait_r;                       // Settling counter
   logic       ap_r;                         // Auto precharge pending

   // Bank sequencing
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         state    <= sdc_pkg::BK_IDLE;
         wait_r   <= 4'h0;
         ap_r     <= 1'b0;
         open_row <= 13'h0000;
      end
      else if (do_pre)
      begin
         // Precharge closes the row from any state
         state  <= sdc_pkg::BK_PRECHARGING;
         wait_r <= 4'(PRE_CYC);
         ap_r   <= 1'b0;
      end
      else if (do_act && state == sdc_pkg::BK_IDLE)
      begin
         state    <= sdc_pkg::BK_ACTIVATING;
         wait_r   <= 4'(ACT_CYC);
         open_row <= row_in;                 // Row held until the next activate
      end
      else if (do_rd || do_wr)
      begin
         state <= do_rd ? sdc_pkg::BK_READING : sdc_pkg::BK_WRITING;
         ap_r  <= ap;
      end
      else
      begin
         case (state)
            sdc_pkg::BK_ACTIVATING, sdc_pkg::BK_PRECHARGING:
            begin
               if (wait_r > 4'h1)
                  wait_r <= wait_r - 4'h1;
               else
                  state <= (state == sdc_pkg::BK_ACTIVATING) ? sdc_pkg::BK_ROW_OPEN
                                                             : sdc_pkg::BK_IDLE;
            end
            sdc_pkg::BK_READING, sdc_pkg::BK_WRITING:
            begin
               if (burst_end)
               begin
                  // Auto precharge when the burst ends, else row stays open
                  if (ap_r)
                  begin
                     state  <= sdc_pkg::BK_PRECHARGING;
                     wait_r <= 4'(PRE_CYC);
                     ap_r   <= 1'b0;
                  end
                  else
                     state <= sdc_pkg::BK_ROW_OPEN;
               end
            end
            default: ;
         endcase
      end
   end
endmodule // sdc_bank
`default_nettype wire

// File: rtl/sdc_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdc_map.svh"
module sdc_core #(
   parameter int DQ_W     = 8,                // 4, 8 or 16
   parameter int COL_W    = 10,               // 11, 10 or 9
   parameter int BURST    = 8,                // Programmed burst length, 0 = full page
   parameter int SELF_DIV = `SDC_SELF_TICK_DIV // Self refresh tick, shortened in sim
) (
   input  wire logic                  mclk,
   input  wire logic                  reset,
   input  wire sdc_pkg::sdc_cmd_type  cmd,
   input  wire logic                  dqm,
   input  wire logic [DQ_W-1:0]       dq_in,
   input  wire logic                  no_self_refresh,
   output logic [DQ_W-1:0]            dq_out,
   output logic                       dq_oe_n,
   output logic [`SDC_MODE_W-1:0]     mode_r,
   output logic [`SDC_ROW_W-1:0]      refresh_row_r,
   output logic                       self_refresh_r,
   output logic [`SDC_BANKS-1:0]      bank_open_r,
   output logic                       wr_en_r,
   output logic [1:0]                 wr_bank_r,
   output logic [COL_W-1:0]           wr_col_r,
   output logic [DQ_W-1:0]            wr_data_r,
   output logic [1:0]                 rd_bank_r,
   output logic [COL_W-1:0]           rd_col_r
);
   localparam int PRE_CYC = `SDC_CYC(`SDC_PRE_WAIT_NS);
   localparam int ACT_CYC = `SDC_CYC(`SDC_ACT_WAIT_NS);
   localparam int REF_CYC = `SDC_CYC(`SDC_REF_WAIT_NS);

   sdc_pkg::sdc_dec_type        dec;           // Decoded command
   sdc_pkg::sdc_bank_state_type bst [`SDC_BANKS]; // Per-bank states
   logic [12:0]                 brow [`SDC_BANKS]; // Open rows
   logic [`SDC_BANKS-1:0]       pre_sel;       // Banks to precharge
   logic                        all_idle;      // Every bank idle and no refresh running
   logic                        burst_act_r;   // A burst is running
   logic                        burst_rd_r;    // Running burst is a read
   logic [COL_W-1:0]            bcnt_r;        // Beats left
   logic [1:0]                  bbank_r;       // Bank of running burst
   logic [COL_W-1:0]            bcol_r;        // Current column
   logic                        burst_end;     // Burst finishes this cycle
   logic [1:0]                  rdv_pipe_r;    // Read beat pipeline
   logic [1:0]                  dqm_pipe_r;    // Read DQM pipeline
   logic [7:0]                  ref_busy_r;    // Refresh cycle counter
   logic [15:0]                 self_div_r;    // Internal refresh divider
   logic [COL_W-1:0]            col_in;        // Column field

   // Command decode, combinational from the sampled pins
   always_comb
   begin
      if (cmd.cs_n)
         dec = sdc_pkg::DC_INHIBIT;
      else
      begin
         case ({cmd.ras_n, cmd.cas_n, cmd.we_n})
            `SDC_CMD_ACT: dec = sdc_pkg::DC_ACT;
            `SDC_CMD_RD:  dec = sdc_pkg::DC_RD;
            `SDC_CMD_WR:  dec = sdc_pkg::DC_WR;
            `SDC_CMD_BST: dec = sdc_pkg::DC_BST;
            `SDC_CMD_PRE: dec = sdc_pkg::DC_PRE;
            `SDC_CMD_REF: dec = cmd.cke ? sdc_pkg::DC_AREF : sdc_pkg::DC_SREF;
            `SDC_CMD_LMR: dec = sdc_pkg::DC_LMR;
            default:      dec = sdc_pkg::DC_NOP;
         endcase
      end
   end

   // Column field per width: x4 adds A11 on top
   always_comb
   begin
      if (COL_W > 10)
         col_in = COL_W'({cmd.addr[`SDC_COL_X4_HI], cmd.addr[9:0]});
      else
         col_in = cmd.addr[COL_W-1:0];
   end

   // Precharge targets: A10 high selects all and ignores BA
   always_comb
   begin
      pre_sel = '0;
      if (dec == sdc_pkg::DC_PRE && !self_refresh_r)
      begin
         if (cmd.addr[`SDC_AP_BIT])
            pre_sel = '1;
         else
            pre_sel[cmd.ba] = 1'b1;
      end
   end

   assign all_idle  = (bst[0] == sdc_pkg::BK_IDLE) && (bst[1] == sdc_pkg::BK_IDLE)
                   && (bst[2] == sdc_pkg::BK_IDLE) && (bst[3] == sdc_pkg::BK_IDLE)
                   && (ref_busy_r == 8'h00);   // A running refresh keeps the device busy
   assign burst_end = burst_act_r && (bcnt_r == COL_W'(1))
                   && !(dec inside {sdc_pkg::DC_RD, sdc_pkg::DC_WR});

   // One state machine per bank
   genvar g;
   generate
      for (g = 0; g < `SDC_BANKS; g++)
      begin : g_bank
         logic hit;                            // Command addresses this bank
         assign hit = (cmd.ba == 2'(g)) && !self_refresh_r;
         sdc_bank #(.PRE_CYC(PRE_CYC), .ACT_CYC(ACT_CYC)) u_bank (
            .mclk      (mclk),
            .reset     (reset),
            .do_act    (hit && dec == sdc_pkg::DC_ACT),
            .do_pre    (pre_sel[g]),
            .do_rd     (hit && dec == sdc_pkg::DC_RD),
            .do_wr     (hit && dec == sdc_pkg::DC_WR),
            .burst_end ((burst_end || (burst_act_r && dec == sdc_pkg::DC_BST))
                        && bbank_r == 2'(g)),
            .ap        (cmd.addr[`SDC_AP_BIT]),
            .row_in    (cmd.addr),
            .state     (bst[g]),
            .open_row  (brow[g])
         );
      end
   endgenerate

   // Open-row flags for the outside
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         bank_open_r <= '0;
      else
         for (int i = 0; i < `SDC_BANKS; i++)
            bank_open_r[i] <= (bst[i] != sdc_pkg::BK_IDLE)
                           && (bst[i] != sdc_pkg::BK_PRECHARGING);
   end

   // Burst tracker; a new READ/WRITE or terminate cuts the running burst
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         burst_act_r <= 1'b0;
         burst_rd_r  <= 1'b0;
         bcnt_r      <= '0;
         bbank_r     <= 2'h0;
         bcol_r      <= '0;
      end
      else if (!self_refresh_r && (dec == sdc_pkg::DC_RD || dec == sdc_pkg::DC_WR))
      begin
         burst_act_r <= 1'b1;
         burst_rd_r  <= (dec == sdc_pkg::DC_RD);
         bcnt_r      <= (BURST == 0) ? '0 : COL_W'(BURST);
         bbank_r     <= cmd.ba;
         bcol_r      <= col_in;
      end
      else if (dec == sdc_pkg::DC_BST || pre_sel[bbank_r])
         burst_act_r <= 1'b0;
      else if (burst_act_r)
      begin
         // Full page (count 0) wraps the count and ends after a whole page of beats unless cut
         if (burst_end)
            burst_act_r <= 1'b0;
         bcnt_r <= bcnt_r - COL_W'(1);
         bcol_r <= bcol_r + COL_W'(1);
      end
   end

   // Write beats: DQM in the same cycle masks the data
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         wr_en_r   <= 1'b0;
         wr_bank_r <= 2'h0;
         wr_col_r  <= '0;
         wr_data_r <= '0;
      end
      else
      begin
         wr_en_r   <= 1'b0;
         if (!self_refresh_r && dec == sdc_pkg::DC_WR)
         begin
            wr_en_r   <= !dqm;
            wr_bank_r <= cmd.ba;
            wr_col_r  <= col_in;
            wr_data_r <= dq_in;
         end
         else if (burst_act_r && !burst_rd_r && !burst_end && dec != sdc_pkg::DC_BST)
         begin
            wr_en_r   <= !dqm;
            wr_bank_r <= bbank_r;
            wr_col_r  <= bcol_r + COL_W'(1);
            wr_data_r <= dq_in;
         end
      end
   end

   // Read address and DQM pipelines, two clocks to the pins
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         rdv_pipe_r <= 2'b00;
         dqm_pipe_r <= 2'b11;
         rd_bank_r  <= 2'h0;
         rd_col_r   <= '0;
      end
      else
      begin
         rdv_pipe_r <= {rdv_pipe_r[0],
                        (!self_refresh_r && dec == sdc_pkg::DC_RD)
                        || (burst_act_r && burst_rd_r && !burst_end)};
         dqm_pipe_r <= {dqm_pipe_r[0], dqm};
         rd_bank_r  <= (dec == sdc_pkg::DC_RD) ? cmd.ba : bbank_r;
         rd_col_r   <= (dec == sdc_pkg::DC_RD) ? col_in : bcol_r + COL_W'(1);
      end
   end

   // Read data drive; memory array lives outside, loopback of write data stands in
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         dq_oe_n <= 1'b1;
         dq_out  <= '0;
      end
      else
      begin
         dq_oe_n <= !(rdv_pipe_r[1] && !dqm_pipe_r[1]); // Masked beat floats
         dq_out  <= wr_data_r;
      end
   end

   // Mode register load, only honoured with all banks idle
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         mode_r <= `SDC_MODE_RST;
      else if (dec == sdc_pkg::DC_LMR && all_idle && !self_refresh_r)
         mode_r <= cmd.addr[`SDC_MODE_W-1:0];
   end

   // Refresh: auto or self share one row counter
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         refresh_row_r  <= '0;
         self_refresh_r <= 1'b0;
         ref_busy_r     <= 8'h00;
         self_div_r     <= 16'h0000;
      end
      else if (self_refresh_r)
      begin
         // Inputs ignored save CKE; internal timer refreshes rows
         if (cmd.cke)
            self_refresh_r <= 1'b0;
         if (self_div_r >= 16'(SELF_DIV - 1))
         begin
            self_div_r    <= 16'h0000;
            refresh_row_r <= refresh_row_r + 13'h0001;
         end
         else
            self_div_r <= self_div_r + 16'h0001;
      end
      else
      begin
         if (ref_busy_r != 8'h00)
            ref_busy_r <= ref_busy_r - 8'h01;
         if (dec == sdc_pkg::DC_AREF && all_idle)
         begin
            refresh_row_r <= refresh_row_r + 13'h0001; // Address ignored
            ref_busy_r    <= 8'(REF_CYC);
         end
         else if (dec == sdc_pkg::DC_SREF && all_idle && !no_self_refresh)
         begin
            self_refresh_r <= 1'b1;
            self_div_r     <= 16'h0000;
         end
      end
   end

   // A WRITE command beat with DQM high is not stored
   property p_wr_mask;
      @(posedge mclk) disable iff (reset)
      (dec == sdc_pkg::DC_WR && dqm && !self_refresh_r) |=> !wr_en_r;
   endproperty
   a_wr_mask: assert property (p_wr_mask) else $error("masked write beat stored");

   // Read DQM high floats the pins two clocks later plus output stage
   property p_rd_dqm;
      @(posedge mclk) disable iff (reset)
      dqm |-> ##3 dq_oe_n;
   endproperty
   a_rd_dqm: assert property (p_rd_dqm) else $error("read DQM did not float DQ");

   // Precharge all closes every bank
   property p_pre_all;
      @(posedge mclk) disable iff (reset)
      (dec == sdc_pkg::DC_PRE && cmd.addr[`SDC_AP_BIT] && !self_refresh_r)
      |=> ##1 (bank_open_r == '0);
   endproperty
   a_pre_all: assert property (p_pre_all) else $error("precharge all left a row open");

   // Self refresh refused when disabled
   property p_no_sref;
      @(posedge mclk) disable iff (reset)
      (no_self_refresh && !self_refresh_r) |=> !self_refresh_r;
   endproperty
   a_no_sref: assert property (p_no_sref) else $error("self refresh entered while disabled");

   // Auto refresh advances the row counter by one
   property p_aref_row;
      @(posedge mclk) disable iff (reset)
      (dec == sdc_pkg::DC_AREF && all_idle && !self_refresh_r)
      |=> refresh_row_r == $past(refresh_row_r) + 13'h0001;
   endproperty
   a_aref_row: assert property (p_aref_row) else $error("auto refresh row not advanced");

   // Inhibit leaves the mode register unchanged
   property p_inhibit;
      @(posedge mclk) disable iff (reset)
      (dec == sdc_pkg::DC_INHIBIT) |=> $stable(mode_r);
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("inhibit altered mode");

   // Terminate stops the burst at once
   property p_bst;
      @(posedge mclk) disable iff (reset)
      (dec == sdc_pkg::DC_BST) |=> !burst_act_r;
   endproperty
   a_bst: assert property (p_bst) else $error("burst survived terminate");

   // Activate to bank 0 records the row in that bank
   property p_act_row;
      @(posedge mclk) disable iff (reset)
      (dec == sdc_pkg::DC_ACT && cmd.ba == 2'h0 && bst[0] == sdc_pkg::BK_IDLE
       && !self_refresh_r) |=> brow[0] == $past(cmd.addr);
   endproperty
   a_act_row: assert property (p_act_row) else $error("activated row not held");
endmodule // sdc_core
`default_nettype wire

// File: testbench/sdc_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdc_map.svh"
// Controller stand-in; every task starts just after a falling edge and ends on one
module sdc_ctl_model #(
   parameter int DQ_W   = 8,
   parameter int BURST  = 4,
   parameter int EXIT_W = 16 // Self refresh exit wait, plain default
) (
   input  wire logic            mclk,
   output sdc_pkg::sdc_cmd_type cmd,
   output logic                 dqm,
   output logic [DQ_W-1:0]      dq_in
);
   localparam int PRE_W = `SDC_CYC(`SDC_PRE_WAIT_NS); // Precharge wait
   localparam int ACT_W = `SDC_CYC(`SDC_ACT_WAIT_NS); // Activate to access
   localparam int REF_W = `SDC_CYC(`SDC_REF_WAIT_NS); // Refresh cycle wait
   int seed = 32'h530d_cc16; // Noise stream for idle pins
   // Start deselected with cke high
   initial
   begin
      cmd = 20'h8_8000;
      dqm = 1'b0;
      dq_in = '0;
   end
   // One command edge with the data lane riding along
   task automatic issue(input logic [2:0] code, input logic [1:0] ba, input logic [12:0] a,
                        input logic ck, input logic m, input logic [DQ_W-1:0] d);
      cmd = {1'b0, code, ck, ba, a};
      dqm = m;
      dq_in = d;
      @(negedge mclk);
   endtask
   // Deselect with noise elsewhere; a decoder that ignores cs_n shows up here
   task automatic idle(input int n, input logic m);
      for (int i = 0; i < n; i++)
      begin
         cmd = 20'($random(seed)) | 20'h8_8000;
         dqm = m;
         dq_in = ~dq_in; // Released bus toggles rather than hold a stale beat
         @(negedge mclk);
      end
   endtask
   // Row open, then wait before any access
   task automatic act(input logic [1:0] ba, input logic [12:0] row);
      issue(`SDC_CMD_ACT, ba, row, 1'b1, 1'b0, ~dq_in);
      idle(ACT_W, 1'b0);
   endtask
   // Close one bank or all; bank bits keep the given ba even when all is set
   task automatic pre(input logic [1:0] ba, input logic all);
      issue(`SDC_CMD_PRE, ba, {2'b00, all, 10'h000}, 1'b1, 1'b0, ~dq_in);
      idle(PRE_W, 1'b0);
   endtask
   // Mode load, only issued with every bank idle
   task automatic lmr(input logic [12:0] a);
      issue(`SDC_CMD_LMR, 2'b00, a, 1'b1, 1'b0, ~dq_in);
      idle(2, 1'b0);
   endtask
   // Auto refresh; address carries noise on purpose
   task automatic aref(input logic [12:0] a);
      issue(`SDC_CMD_REF, a[1:0], a, 1'b1, 1'b0, ~dq_in);
      idle(REF_W, 1'b0);
   endtask
   // Write burst; a stop goes out at beat nb with its own data masked
   task automatic wr(input logic [1:0] ba, input logic [12:0] a, input logic [BURST-1:0] m,
                     input logic [BURST*DQ_W-1:0] d, input int nb);
      for (int i = 0; i < BURST; i++)
         if (i == 0)
            issue(`SDC_CMD_WR, ba, a, 1'b1, m[0], d[DQ_W-1:0]);
         else if (i == nb)
            issue(`SDC_CMD_BST, 2'b00, 13'h0000, 1'b1, 1'b1, d[i*DQ_W +: DQ_W]);
         else
            issue(`SDC_CMD_NOP, 2'b00, 13'h0000, 1'b1, m[i], d[i*DQ_W +: DQ_W]);
      idle(PRE_W + 2, 1'b0); // Covers recovery and any auto precharge
   endtask
   // Read burst with one mask level held throughout
   task automatic rd(input logic [1:0] ba, input logic [12:0] a, input logic m);
      issue(`SDC_CMD_RD, ba, a, 1'b1, m, ~dq_in);
      idle(BURST + 4, m);
   endtask
   // Self refresh entry
   task automatic sref_enter();
      issue(`SDC_CMD_REF, 2'b00, 13'h0000, 1'b0, 1'b0, ~dq_in);
   endtask
   // Hold cke low; other command pins are noise, dqm held
   task automatic sref_hold(input int n);
      for (int i = 0; i < n; i++)
      begin
         cmd = 20'($random(seed)) & 20'hf_7fff;
         dq_in = ~dq_in;
         @(negedge mclk);
      end
   endtask
   // Exit: cke high with no-ops for the exit wait
   task automatic sref_exit();
      for (int i = 0; i < EXIT_W; i++)
         issue(`SDC_CMD_NOP, 2'b00, 13'h0000, 1'b1, 1'b0, ~dq_in);
   endtask
endmodule // sdc_ctl_model
`default_nettype wire

// File: testbench/sdc_command_decode_refresh_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sdc_command_decode_refresh_tb;
   localparam int DQ_W  = 8;
   localparam int COL_W = 10;
   localparam int BURST = 4;
   logic                 mclk;
   logic                 reset;
   logic                 no_self_refresh;
   sdc_pkg::sdc_cmd_type cmd;
   logic                 dqm;
   logic [DQ_W-1:0]      dq_in;
   logic [DQ_W-1:0]      dq_out;
   logic                 dq_oe_n;
   logic [11:0]          mode_r;
   logic [12:0]          refresh_row_r;
   logic                 self_refresh_r;
   logic [3:0]           bank_open_r;
   logic                 wr_en_r;
   logic [1:0]           wr_bank_r;
   logic [COL_W-1:0]     wr_col_r;
   logic [DQ_W-1:0]      wr_data_r;
   logic [1:0]           rd_bank_r;
   logic [COL_W-1:0]     rd_col_r;
   int                   num_errors = 0;
   int                   total_checks = 0;
   int                   cyc = 0;          // Rising edges seen
   int                   seed = 32'h530d_cc16;
   logic [63:0]          wq[$];            // Expected write beats with their cycle
   logic [63:0]          oq[$];            // Expected read beats: cycle, address, data
   logic [11:0]          rh1 = '0;         // Read address one clock back
   logic [11:0]          rh2 = '0;         // Read address two clocks back
   // Device under test, self refresh divider shortened for simulation
   sdc_core #(.DQ_W(DQ_W), .COL_W(COL_W), .BURST(BURST), .SELF_DIV(4)) dut_u (
      .mclk(mclk), .reset(reset), .cmd(cmd), .dqm(dqm), .dq_in(dq_in),
      .no_self_refresh(no_self_refresh), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
      .mode_r(mode_r), .refresh_row_r(refresh_row_r), .self_refresh_r(self_refresh_r),
      .bank_open_r(bank_open_r), .wr_en_r(wr_en_r), .wr_bank_r(wr_bank_r),
      .wr_col_r(wr_col_r), .wr_data_r(wr_data_r), .rd_bank_r(rd_bank_r),
      .rd_col_r(rd_col_r)
   );
   // Far-side controller
   sdc_ctl_model #(.DQ_W(DQ_W), .BURST(BURST)) ctl_u (
      .mclk(mclk), .cmd(cmd), .dqm(dqm), .dq_in(dq_in)
   );
   // 200 MHz clock
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // Compare one value and count it
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Verdict and end of run
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Output watcher: sample 1 ns after the edge so registered outputs have settled
   always @(posedge mclk)
   begin
      cyc = cyc + 1;
      #1;
      if (wr_en_r === 1'b1)
         check("write beat", {12'h000, cyc, wr_bank_r, wr_col_r, wr_data_r},
               (wq.size() > 0) ? wq.pop_front() : '1);
      if (dq_oe_n === 1'b0)
         check("read beat", {12'h000, cyc, rh2, dq_out},
               (oq.size() > 0) ? oq.pop_front() : '1);
      // The address of a beat leads its pin drive by two clocks
      rh2 = rh1;
      rh1 = {rd_bank_r, rd_col_r};
   end
   // Hang guard
   initial
   begin
      repeat (3000) @(posedge mclk);
      $display("run did not finish in time");
      num_errors++;
      test_done();
   end
   // Main sequence, stimulus just after falling edges
   initial
   begin : main
      logic [12:0]           a;
      logic [BURST*DQ_W-1:0] d;
      logic [BURST-1:0]      m;
      logic [12:0]           row0;
      logic [11:0]           mode0;
      int                    nb;
      reset = 1'b1;
      no_self_refresh = 1'b1;
      repeat (5) @(posedge mclk);
      check("reset state", {dq_oe_n, mode_r, bank_open_r, self_refresh_r, refresh_row_r},
            {1'b1, 30'h0000_0000});
      @(negedge mclk);
      reset = 1'b0;
      a = 13'($random(seed));
      ctl_u.lmr(a);
      check("mode", mode_r, a[11:0]);
      for (int i = 0; i < 3; i++)
         ctl_u.aref(13'($random(seed)));
      check("refresh row", refresh_row_r, 13'h0003);
      for (int b = 0; b < 4; b++)
         ctl_u.act(2'(b), 13'($random(seed)));
      check("banks open", bank_open_r, 4'hf);
      // Bank 0 is stopped after two beats, bank 3 closes itself
      for (int b = 0; b < 4; b++)
      begin
         a = 13'($random(seed)) & 13'h03fc;
         a[10] = (b == 3);
         d = 32'($random(seed));
         m = (b == 0) ? 4'h0 : 4'($random(seed));
         if (b == 3)
            m[BURST-1] = 1'b0; // Last beat lands; wr_data_r takes masked beats too, so the read loopback shows it regardless
         nb = (b == 0) ? 2 : BURST;
         for (int i = 0; i < nb; i++)
            if (!m[i])
               wq.push_back({12'h000, cyc + 1 + i, 2'(b), a[9:0] + 10'(i), d[i*DQ_W +: DQ_W]});
         ctl_u.wr(2'(b), a, m, d, nb);
      end
      check("auto precharge", bank_open_r, 4'h7);
      for (int i = 0; i < BURST; i++)
         oq.push_back({12'h000, cyc + 3 + i, 2'd1, 10'h010 + 10'(i), d[BURST*DQ_W-1 -: DQ_W]});
      ctl_u.rd(2'd1, 13'h0010, 1'b0);
      ctl_u.rd(2'd2, 13'h0020, 1'b1);
      check("pending results", {wq.size(), oq.size()}, 64'h0);
      ctl_u.pre(2'd1, 1'b0);
      check("single precharge", bank_open_r, 4'h5);
      ctl_u.pre(2'd1, 1'b1);
      check("all precharge", bank_open_r, 4'h0);
      // Refused entry, then a real stay with noisy pins
      ctl_u.sref_enter();
      check("self refresh refused", self_refresh_r, 1'b0);
      ctl_u.sref_exit();
      no_self_refresh = 1'b0;
      row0 = refresh_row_r;
      mode0 = mode_r;
      ctl_u.sref_enter();
      ctl_u.sref_hold(60);
      check("self refresh on", self_refresh_r, 1'b1);
      check("internal refresh ran", refresh_row_r != row0, 1'b1);
      ctl_u.sref_exit();
      check("after self refresh", {self_refresh_r, bank_open_r, mode_r},
            {1'b0, 4'h0, mode0});
      row0 = refresh_row_r;
      ctl_u.aref(13'($random(seed)));
      check("refresh resumes", refresh_row_r, row0 + 13'h0001);
      test_done();
   end
endmodule // sdc_command_decode_refresh_tb
`default_nettype wire
